// file: verilog/boot_seq_pkg.sv
package boot_seq_pkg;
    // boot sources chosen by the four mode pins
    typedef enum logic [3:0] {
        src_parallel,
        src_master_ram,
        src_serial_slave,
        src_can,
        src_ethernet_a,
        src_ethernet_b,
        src_flash,
        src_flash_fast,
        src_otp,
        src_ssi_master,
        src_i2c_master
    } boot_src_t;

    // boot mode pin codes
    localparam logic [3:0] mode_parallel = 4'h0;
    localparam logic [3:0] mode_ram = 4'h1;
    localparam logic [3:0] mode_serial = 4'h2;
    localparam logic [3:0] mode_can = 4'h3;
    localparam logic [3:0] mode_eth_a = 4'h4;
    localparam logic [3:0] mode_otp = 4'h6;
    localparam logic [3:0] mode_flash = 4'h7;
    localparam logic [3:0] mode_ssi_m = 4'h9;
    localparam logic [3:0] mode_i2c_m = 4'ha;
    localparam logic [3:0] mode_eth_b = 4'hc;
    localparam logic [3:0] mode_flash_fast = 4'hf;

    // width of the boot pin field
    localparam int mode_bits = 4;

    // control cpu boot vector, top entry of its boot rom vector table
    localparam logic [21:0] control_vector_reset = 22'h3fffc0;

    // device configuration word bit positions
    localparam int cfg_bit_bus_reset = 0;
    localparam int cfg_bit_ext_reset = 1;
    localparam int cfg_width = 2;
endpackage

// file: verilog/pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module pin_sync #(
    parameter int width = 1,
    parameter logic [0:0] reset_val = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // data
    input wire logic [width-1:0] din,
    output logic [width-1:0] dout
);
    // a zero-width synchroniser has nothing to carry
    if (width < 1)
    begin : g_bad_width
        $error("pin_sync needs at least one bit");
    end

    typedef struct packed {
        logic [width-1:0] s1;
        logic [width-1:0] s2;
        logic [width-1:0] s3;
        logic [width-1:0] q;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < width; i++)
        begin
            if (st_reg.s2[i] == st_reg.s3[i])
            begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg <= {4 * width{reset_val}};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.q;
endmodule // pin_sync

// file: verilog/reset_boot_seq.sv
`timescale 1ns/1ps
// Overview of operation
// - control cpu reset from pin, control nmi watchdog, sw, debug, selective reset
// - control subsystem reset follows the control cpu reset
// - after reset, control cpu starts at top boot rom vector
// - sw and debug resets reach control cpu directly only when each is enabled; either one also restarts boot, which holds control cpu
// - master software may assert selective control reset; master keeps running
// - analog bus reset and pin reset state readable in config word
// - shared reset from pin, sw, debug; clears analog, ipc, message and shared ram
// - sw and debug feed shared reset only when propagation enabled
// - analog also reset by analog bus reset and analog reset pin
// - external peripheral interface reset by master system reset
// - boot starts whenever master leaves reset, for any cause
// - on release only master runs; control and analog held until released
// - order: device init, master init, then release control and analog
// - control idles after init until master ipc interrupt one
// - after control release, sample four mode pins, pin four msb
// - codes 0..3 select parallel, ram, serial slave, can
// - codes 4 and 12 select ethernet on different pin sets
// - codes 7 and 15 flash, code 6 otp
// - code 9 ssi master, code 10 i2c master
// - codes 5, 8, 11, 13, 14 fall back to flash
module reset_boot_seq (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // reset sources (pins active low, internal active high)
    input wire logic ext_reset_pin_n,
    input wire logic analog_reset_pin_n,
    input wire logic control_nmi_wd_timeout,
    input wire logic master_wd_reset,
    input wire logic master_sw_reset,
    input wire logic master_debug_reset,
    // master software controls
    input wire logic sw_to_control_en,
    input wire logic debug_to_control_en,
    input wire logic sw_to_shared_en,
    input wire logic debug_to_shared_en,
    input wire logic master_sel_control_reset,
    input wire logic analog_bus_reset,
    // master boot progress strobes
    input wire logic device_init_done,
    input wire logic master_init_done,
    input wire logic control_init_done,
    input wire logic m2c_ipc_int_one,
    // boot mode pins
    input wire logic boot_sel_bit0,
    input wire logic boot_sel_bit1,
    input wire logic boot_sel_bit2,
    input wire logic boot_sel_bit3,
    // reset outputs, active high
    output logic master_sys_reset,
    output logic control_cpu_reset_in,
    output logic control_subsys_reset,
    output logic shared_res_reset,
    output logic analog_reset,
    output logic external_periph_if_reset,
    // control cpu start and idle
    output logic [21:0] control_start_addr,
    output logic control_idle,
    // boot status
    output logic boot_active,
    output logic boot_mode_valid,
    output logic [3:0] boot_mode_code,
    output boot_seq_pkg::boot_src_t boot_src,
    output logic [boot_seq_pkg::cfg_width-1:0] device_config_reg
);
    typedef enum logic [2:0] {
        st_hold,
        st_dev_init,
        st_master_init,
        st_release,
        st_sample,
        st_running
    } seq_t;

    typedef struct packed {
        seq_t seq;
        logic active;
        logic master_rst;
        logic ctrl_rst;
        logic ctrl_sub_rst;
        logic shared_rst;
        logic analog_rst;
        logic epi_rst;
        logic ctrl_held;
        logic analog_held;
        logic idle;
        logic mode_valid;
        logic [3:0] mode;
        boot_seq_pkg::boot_src_t src;
        logic [boot_seq_pkg::cfg_width-1:0] cfg;
        logic [21:0] vec;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic ext_n_s;
    logic ana_n_s;
    logic [3:0] pins_s;

    // decode of a pin code into a boot source
    function automatic boot_seq_pkg::boot_src_t decode_mode(input logic [3:0] code);
        case (code)
            boot_seq_pkg::mode_parallel: decode_mode = boot_seq_pkg::src_parallel;
            boot_seq_pkg::mode_ram: decode_mode = boot_seq_pkg::src_master_ram;
            boot_seq_pkg::mode_serial: decode_mode = boot_seq_pkg::src_serial_slave;
            boot_seq_pkg::mode_can: decode_mode = boot_seq_pkg::src_can;
            boot_seq_pkg::mode_eth_a: decode_mode = boot_seq_pkg::src_ethernet_a;
            boot_seq_pkg::mode_eth_b: decode_mode = boot_seq_pkg::src_ethernet_b;
            boot_seq_pkg::mode_otp: decode_mode = boot_seq_pkg::src_otp;
            boot_seq_pkg::mode_flash: decode_mode = boot_seq_pkg::src_flash;
            boot_seq_pkg::mode_flash_fast: decode_mode = boot_seq_pkg::src_flash_fast;
            boot_seq_pkg::mode_ssi_m: decode_mode = boot_seq_pkg::src_ssi_master;
            boot_seq_pkg::mode_i2c_m: decode_mode = boot_seq_pkg::src_i2c_master;
            default: decode_mode = boot_seq_pkg::src_flash;
        endcase
    endfunction

    // a master sw or debug reset feeds control or shared reset directly only while its enable is set; it still holds control through the master restart
    function automatic logic gated(input logic src, input logic en);
        gated = src && en;
    endfunction

    pin_sync #(
        .width(2),
        .reset_val(1'b0)
    ) u_rst_sync (
        .clk(clk),
        .nrst(nrst),
        .din({ext_reset_pin_n, analog_reset_pin_n}),
        .dout({ext_n_s, ana_n_s})
    );

    pin_sync #(
        .width(boot_seq_pkg::mode_bits),
        .reset_val(1'b0)
    ) u_mode_sync (
        .clk(clk),
        .nrst(nrst),
        .din({boot_sel_bit3, boot_sel_bit2, boot_sel_bit1, boot_sel_bit0}),
        .dout(pins_s)
    );

    // the decode table and the config word layout only serve these sizes
    if (boot_seq_pkg::mode_bits != $bits(boot_mode_code))
    begin : g_bad_mode_bits
        $error("boot mode field width does not match the mode pins");
    end
    if (boot_seq_pkg::cfg_bit_bus_reset >= boot_seq_pkg::cfg_width
        || boot_seq_pkg::cfg_bit_ext_reset >= boot_seq_pkg::cfg_width)
    begin : g_bad_cfg
        $error("config word too narrow for its status bits");
    end
    if ($bits(boot_seq_pkg::control_vector_reset) != $bits(control_start_addr))
    begin : g_bad_vector
        $error("control start vector width does not match its output");
    end

    logic ext_rst;
    logic sw_ctrl;
    logic dbg_ctrl;
    logic sw_sh;
    logic dbg_sh;
    logic master_cause;
    logic ana_rst;
    logic shared_cause;
    logic ctrl_cause;
    logic analog_cause;

    always_comb
    begin
        ext_rst = !ext_n_s;
        ana_rst = !ana_n_s;
        sw_ctrl = gated(master_sw_reset, sw_to_control_en);
        dbg_ctrl = gated(master_debug_reset, debug_to_control_en);
        sw_sh = gated(master_sw_reset, sw_to_shared_en);
        dbg_sh = gated(master_debug_reset, debug_to_shared_en);
        // every cause of a master system reset, enabled or not
        master_cause = ext_rst || master_wd_reset || master_sw_reset || master_debug_reset;
        shared_cause = ext_rst || sw_sh || dbg_sh;
        // selective reset reaches only the control side
        ctrl_cause = ext_rst || control_nmi_wd_timeout || sw_ctrl || dbg_ctrl
            || master_sel_control_reset;
        analog_cause = shared_cause || analog_bus_reset || ana_rst;
    end

    always_comb
    begin
        st_next = st_reg;
        st_next.master_rst = master_cause;
        st_next.epi_rst = master_cause;
        st_next.shared_rst = shared_cause;
        // control and analog stay held by the sequencer until released
        st_next.ctrl_rst = ctrl_cause || st_reg.ctrl_held;
        st_next.ctrl_sub_rst = st_next.ctrl_rst;
        st_next.analog_rst = analog_cause || st_reg.analog_held;
        st_next.cfg[boot_seq_pkg::cfg_bit_bus_reset] = analog_bus_reset;
        st_next.cfg[boot_seq_pkg::cfg_bit_ext_reset] = ext_rst;
        // control idles after its own init until woken
        if (st_reg.ctrl_rst)
        begin
            st_next.idle = 1'b0;
        end
        else if (m2c_ipc_int_one)
        begin
            st_next.idle = 1'b0;
        end
        else if (control_init_done)
        begin
            st_next.idle = 1'b1;
        end
        case (st_reg.seq)
            st_hold:
            begin
                if (!master_cause)
                begin
                    st_next.seq = st_dev_init;
                end
            end
            st_dev_init:
            begin
                if (device_init_done)
                begin
                    st_next.seq = st_master_init;
                end
            end
            st_master_init:
            begin
                if (master_init_done)
                begin
                    st_next.seq = st_release;
                end
            end
            st_release:
            begin
                st_next.ctrl_held = 1'b0;
                st_next.analog_held = 1'b0;
                st_next.seq = st_sample;
            end
            st_sample:
            begin
                st_next.mode = pins_s;
                st_next.src = decode_mode(pins_s);
                st_next.mode_valid = 1'b1;
                st_next.seq = st_running;
            end
            st_running:
            begin
                st_next.seq = st_running;
            end
            default:
            begin
                st_next.seq = st_hold;
            end
        endcase
        // any master reset restarts the whole sequence
        if (master_cause)
        begin
            st_next.seq = st_hold;
            st_next.ctrl_held = 1'b1;
            st_next.analog_held = 1'b1;
            st_next.mode_valid = 1'b0;
        end
        // status and start vector leave the block straight from flops
        st_next.active = (st_next.seq != st_running);
        st_next.vec = boot_seq_pkg::control_vector_reset;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg.seq <= st_hold;
            st_reg.active <= 1'h1;
            st_reg.master_rst <= 1'b1;
            st_reg.ctrl_rst <= 1'b1;
            st_reg.ctrl_sub_rst <= 1'b1;
            st_reg.shared_rst <= 1'b1;
            st_reg.analog_rst <= 1'b1;
            st_reg.epi_rst <= 1'b1;
            st_reg.ctrl_held <= 1'b1;
            st_reg.analog_held <= 1'b1;
            st_reg.idle <= 1'b0;
            st_reg.mode_valid <= 1'b0;
            st_reg.mode <= boot_seq_pkg::mode_parallel;
            st_reg.src <= boot_seq_pkg::src_flash;
            st_reg.cfg <= '0;
            st_reg.vec <= boot_seq_pkg::control_vector_reset;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    always_comb
    begin
        master_sys_reset = st_reg.master_rst;
        control_cpu_reset_in = st_reg.ctrl_rst;
        control_subsys_reset = st_reg.ctrl_sub_rst;
        shared_res_reset = st_reg.shared_rst;
        analog_reset = st_reg.analog_rst;
        external_periph_if_reset = st_reg.epi_rst;
        control_start_addr = st_reg.vec;
        control_idle = st_reg.idle;
        boot_active = st_reg.active;
        boot_mode_valid = st_reg.mode_valid;
        boot_mode_code = st_reg.mode;
        boot_src = st_reg.src;
        device_config_reg = st_reg.cfg;
    end
endmodule // reset_boot_seq

// file: tb/reset_boot_seq_checker.sv
`timescale 1ns/1ps
module reset_boot_seq_checker (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // sources
    input wire logic ext_reset_pin_n,
    input wire logic control_nmi_wd_timeout,
    input wire logic master_sw_reset,
    input wire logic master_debug_reset,
    input wire logic sw_to_shared_en,
    input wire logic analog_bus_reset,
    input wire logic m2c_ipc_int_one,
    // watched outputs
    input wire logic master_sys_reset,
    input wire logic control_cpu_reset_in,
    input wire logic control_subsys_reset,
    input wire logic shared_res_reset,
    input wire logic analog_reset,
    input wire logic control_idle,
    input wire logic boot_mode_valid,
    input wire logic [3:0] boot_mode_code,
    input wire logic [boot_seq_pkg::cfg_width-1:0] device_config_reg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_nmi;
        control_nmi_wd_timeout |=> control_cpu_reset_in;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi timeout missed");
    property p_subsys;
        control_subsys_reset == control_cpu_reset_in;
    endproperty
    a_subsys: assert property (p_subsys) else $error("subsystem reset split");
    property p_sw_shared;
        master_sw_reset && sw_to_shared_en |=> shared_res_reset;
    endproperty
    a_sw_shared: assert property (p_sw_shared) else $error("shared reset missed");
    property p_shared_off;
        (ext_reset_pin_n && !master_sw_reset && !master_debug_reset) [*5] |=> !shared_res_reset;
    endproperty
    a_shared_off: assert property (p_shared_off) else $error("shared reset stuck");
    property p_bus;
        analog_bus_reset |=> analog_reset && device_config_reg[0];
    endproperty
    a_bus: assert property (p_bus) else $error("bus reset missed");
    property p_hold;
        master_sys_reset |=> control_cpu_reset_in && analog_reset;
    endproperty
    a_hold: assert property (p_hold) else $error("control freed early");
    property p_mode;
        boot_mode_valid && $past(boot_mode_valid) |-> $stable(boot_mode_code);
    endproperty
    a_mode: assert property (p_mode) else $error("boot mode moved");
    property p_wake;
        control_idle && m2c_ipc_int_one |=> !control_idle;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");

    c_boot: cover property ($rose(boot_mode_valid));
    c_wake: cover property ($fell(control_idle));
    c_shared: cover property ($rose(shared_res_reset));
endmodule // reset_boot_seq_checker

bind reset_boot_seq reset_boot_seq_checker reset_boot_seq_checker_inst (
    .clk, .nrst, .ext_reset_pin_n, .control_nmi_wd_timeout, .master_sw_reset,
    .master_debug_reset, .sw_to_shared_en, .analog_bus_reset, .m2c_ipc_int_one,
    .master_sys_reset, .control_cpu_reset_in, .control_subsys_reset, .shared_res_reset,
    .analog_reset, .control_idle, .boot_mode_valid, .boot_mode_code, .device_config_reg
);

// file: tb/master_side_model.sv
`timescale 1ns/1ps
module master_side_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // reset state from the sequencer
    input wire logic master_sys_reset,
    input wire logic control_cpu_reset_in,
    // pace: high answers slowly
    input wire logic slow,
    // boot progress strobes
    output logic device_init_done,
    output logic master_init_done,
    output logic control_init_done
);
    logic [3:0] m_cnt_reg;
    logic [3:0] c_cnt_reg;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            m_cnt_reg <= 4'h0;
            c_cnt_reg <= 4'h0;
        end
        else
        begin
            if (master_sys_reset)
                m_cnt_reg <= 4'h0;
            else if (m_cnt_reg != 4'hf)
                m_cnt_reg <= m_cnt_reg + 4'h1;
            if (control_cpu_reset_in)
                c_cnt_reg <= 4'h0;
            else if (c_cnt_reg != 4'hf)
                c_cnt_reg <= c_cnt_reg + 4'h1;
        end
    end

    // device functions first, then the master subsystem
    assign device_init_done = m_cnt_reg == (slow ? 4'h6 : 4'h2);
    assign master_init_done = m_cnt_reg == (slow ? 4'hb : 4'h4);
    // control side parks its cpu once its init is done
    assign control_init_done = c_cnt_reg == 4'h3;
endmodule // master_side_model

// file: tb/reset_boot_seq_tb.sv
`timescale 1ns/1ps
`define check(nm, ex, got) \
    begin compares++; if ((got) !== (ex)) begin fails++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module reset_boot_seq_tb;
    logic clk, nrst, ext_reset_pin_n, analog_reset_pin_n, control_nmi_wd_timeout;
    logic master_wd_reset, master_sw_reset, master_debug_reset, sw_to_control_en;
    logic debug_to_control_en, sw_to_shared_en, debug_to_shared_en, master_sel_control_reset;
    logic analog_bus_reset, device_init_done, master_init_done, control_init_done;
    logic m2c_ipc_int_one, boot_sel_bit0, boot_sel_bit1, boot_sel_bit2, boot_sel_bit3, slow;
    logic master_sys_reset, control_cpu_reset_in, control_subsys_reset, shared_res_reset;
    logic analog_reset, external_periph_if_reset, control_idle, boot_active, boot_mode_valid;
    logic [21:0] control_start_addr;
    logic [3:0] boot_mode_code;
    boot_seq_pkg::boot_src_t boot_src;
    logic [boot_seq_pkg::cfg_width-1:0] device_config_reg;
    logic [6:0] seen;
    int fails = 0;
    int compares = 0;

    assign seen = {master_sys_reset, external_periph_if_reset, control_cpu_reset_in,
        shared_res_reset, analog_reset, device_config_reg};

    reset_boot_seq reset_boot_seq_inst (
        .clk, .nrst, .ext_reset_pin_n, .analog_reset_pin_n, .control_nmi_wd_timeout,
        .master_wd_reset, .master_sw_reset, .master_debug_reset, .sw_to_control_en,
        .debug_to_control_en, .sw_to_shared_en, .debug_to_shared_en,
        .master_sel_control_reset, .analog_bus_reset, .device_init_done, .master_init_done,
        .control_init_done, .m2c_ipc_int_one, .boot_sel_bit0, .boot_sel_bit1, .boot_sel_bit2,
        .boot_sel_bit3, .master_sys_reset, .control_cpu_reset_in, .control_subsys_reset,
        .shared_res_reset, .analog_reset, .external_periph_if_reset, .control_start_addr,
        .control_idle, .boot_active, .boot_mode_valid, .boot_mode_code, .boot_src,
        .device_config_reg
    );

    master_side_model master_side_model_inst (
        .clk, .nrst, .master_sys_reset, .control_cpu_reset_in, .slow,
        .device_init_done, .master_init_done, .control_init_done
    );

    task automatic finish_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic boot_seq_pkg::boot_src_t exp_src(input logic [3:0] c);
        case (c)
            4'h0: return boot_seq_pkg::src_parallel;
            4'h1: return boot_seq_pkg::src_master_ram;
            4'h2: return boot_seq_pkg::src_serial_slave;
            4'h3: return boot_seq_pkg::src_can;
            4'h4: return boot_seq_pkg::src_ethernet_a;
            4'hc: return boot_seq_pkg::src_ethernet_b;
            4'h6: return boot_seq_pkg::src_otp;
            4'h9: return boot_seq_pkg::src_ssi_master;
            4'ha: return boot_seq_pkg::src_i2c_master;
            4'hf: return boot_seq_pkg::src_flash_fast;
            default: return boot_seq_pkg::src_flash;
        endcase
    endfunction

    task automatic quiet;
        {ext_reset_pin_n, analog_reset_pin_n} = 2'b11;
        {control_nmi_wd_timeout, master_sw_reset, master_debug_reset} = 3'h0;
        {sw_to_control_en, debug_to_control_en, sw_to_shared_en, debug_to_shared_en} = 4'h0;
        {master_sel_control_reset, analog_bus_reset} = 2'b00;
    endtask

    task automatic boot(input logic [3:0] code, input logic lag);
        int n;
        {boot_sel_bit3, boot_sel_bit2, boot_sel_bit1, boot_sel_bit0} = code;
        slow = lag;
        master_wd_reset = 1'b1;
        @(posedge clk);
        #1 master_wd_reset = 1'b0;
        `check("active", 1'b1, boot_active)
        n = 0;
        while (master_sys_reset !== 1'b0 && n < 40)
        begin
            @(posedge clk);
            #1 n++;
        end
        `check("held", 1'b1, control_cpu_reset_in)
        while (boot_mode_valid !== 1'b1 && n < 80)
        begin
            @(posedge clk);
            #1 n++;
        end
        `check("run", 2'b00, {control_cpu_reset_in, analog_reset})
        `check("done", 1'h0, boot_active)
        `check("code", code, boot_mode_code)
        `check("src", exp_src(code), boot_src)
        {boot_sel_bit3, boot_sel_bit2, boot_sel_bit1, boot_sel_bit0} = ~code;
        repeat (6) @(posedge clk);
        #1 `check("kept", code, boot_mode_code)
    endtask

    task automatic wake;
        repeat (8) @(posedge clk);
        #1 `check("idle", 1'b1, control_idle)
        m2c_ipc_int_one = 1'b1;
        @(posedge clk);
        #1 m2c_ipc_int_one = 1'b0;
        @(posedge clk);
        #1 `check("awake", 1'b0, control_idle)
        `check("vector", 22'h3fffc0, control_start_addr)
    endtask

    task automatic row(input logic [7:0] s, input logic [6:0] e);
        {ext_reset_pin_n, analog_reset_pin_n} = ~s[7:6];
        {control_nmi_wd_timeout, master_sw_reset, master_debug_reset} = s[5:3];
        {sw_to_control_en, debug_to_control_en, sw_to_shared_en, debug_to_shared_en} = {4{s[2]}};
        {master_sel_control_reset, analog_bus_reset} = s[1:0];
        repeat (8) @(posedge clk);
        #1 `check("resets", e, seen)
        quiet;
        @(posedge clk);
        #1 boot(4'h7, 1'b0);
    endtask

    task automatic restart;
        nrst = 1'h0;
        @(posedge clk);
        #1 `check("in reset", 7'h7c, seen)
        `check("mode cleared", 1'h0, boot_mode_valid)
        repeat (9) @(posedge clk);
        #1 nrst = 1'h1;
        boot(4'ha, 1'h0);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        #(20 * 4000);
        fails++;
        finish_test;
    end

    initial
    begin
        nrst = 1'b0;
        quiet;
        {master_wd_reset, m2c_ipc_int_one, slow} = 3'h0;
        {boot_sel_bit3, boot_sel_bit2, boot_sel_bit1, boot_sel_bit0} = 4'h0;
        repeat (10) @(posedge clk);
        #1 nrst = 1'b1;
        for (int c = 0; c < 16; c++)
            boot(4'(c), c[0]);
        wake;
        row(8'h20, 7'h10);
        row(8'h02, 7'h10);
        row(8'h01, 7'h05);
        row(8'h40, 7'h04);
        row(8'h14, 7'h7c);
        row(8'h10, 7'h74);
        row(8'h0c, 7'h7c);
        row(8'h80, 7'h7e);
        restart;
        wake;
        finish_test;
    end
endmodule // reset_boot_seq_tb
